// ==== design/dic_pkg.sv ====
// constants, carriers and state type of the interrupt controller
package dic_pkg;
  localparam int          DIC_NSRC      = 11;
  localparam logic [3:0]  DIC_STK_DEPTH = 4'hC;
  // register byte offsets
  localparam logic [7:0]  DIC_OFF_MASK   = 8'h00;
  localparam logic [7:0]  DIC_OFF_CTRL   = 8'h04;
  localparam logic [7:0]  DIC_OFF_FC     = 8'h08;
  localparam logic [7:0]  DIC_OFF_GLOBAL = 8'h0C;
  localparam logic [7:0]  DIC_OFF_STATUS = 8'h10;
  localparam logic [7:0]  DIC_OFF_FLAG   = 8'h14;
  // field positions
  localparam int DIC_CTRL_NEST   = 0;
  localparam int DIC_CTRL_EDGE_A = 1;
  localparam int DIC_CTRL_EDGE_B = 2;
  localparam int DIC_CTRL_EDGE_C = 3;
  localparam int DIC_CTRL_RECON  = 4;
  localparam int DIC_CTRL_POWERUP_CONTEXT_RESET_BIT   = 5;
  localparam int DIC_FC_CLR_LSB  = 16;
  localparam int DIC_GL_ON       = 0;
  localparam int DIC_GL_OFF      = 1;
  localparam int DIC_ST_DEPTH_LSB  = 16;
  localparam int DIC_ST_ACTIVE_LSB = 24;
  localparam int DIC_ST_OVF        = 31;
  localparam int DIC_FL_VAL_LSB    = 4;
  localparam int DIC_FL_FLAG_OUT   = 8;
  localparam int DIC_FL_PIN_LSB    = 16;
  localparam int DIC_FL_FLAG_IN    = 20;
  // priority levels, lower index wins
  localparam int DIC_L_PWD    = 0;
  localparam int DIC_L_SEL_A  = 1;
  localparam int DIC_L_LVL_B  = 2;
  localparam int DIC_L_LVL_A  = 3;
  localparam int DIC_L_SP0_TX = 4;
  localparam int DIC_L_SP0_RX = 5;
  localparam int DIC_L_EDGE   = 6;
  localparam int DIC_L_DMA    = 7;
  localparam int DIC_L_SP1_TX = 8;
  localparam int DIC_L_SP1_RX = 9;
  localparam int DIC_L_TIMER  = 10;
  localparam logic [3:0] DIC_L_RESET = 4'hE;
  localparam logic [3:0] DIC_L_NONE  = 4'hF;
  localparam logic [15:0] DIC_VEC_RESET = 16'h0000;
  // vectors indexed by level
  localparam logic [DIC_NSRC-1:0][15:0] DIC_VEC_TABLE = {
    16'h0028, 16'h0024, 16'h0020, 16'h001C, 16'h0018, 16'h0014,
    16'h0010, 16'h000C, 16'h0008, 16'h0004, 16'h002C};
  // pin bit positions inside the synchroniser vector
  localparam int DIC_P_SEL_A = 0;
  localparam int DIC_P_LVL_B = 1;
  localparam int DIC_P_LVL_A = 2;
  localparam int DIC_P_EDGE  = 3;
  localparam int DIC_P_FS_RX = 4;
  localparam int DIC_P_FS_TX = 5;
  localparam int DIC_P_DR    = 6;
  localparam logic [6:0]          DIC_PIN_RST  = 7'h7F;
  localparam logic [DIC_NSRC-1:0] DIC_MASK_RST = 11'h000;
  localparam logic [3:0]          DIC_PFD_RST  = 4'h0;

  typedef struct packed {
    logic sp1_dr;
    logic sp1_fs_tx_n;
    logic sp1_fs_rx_n;
    logic ext_int_edge_n;
    logic ext_int_level_a_n;
    logic ext_int_level_b_n;
    logic ext_int_sel_a_n;
  } dic_pins_t;

  typedef struct packed {
    logic pwd;
    logic timer;
    logic dma;
    logic sp0_tx;
    logic sp0_rx;
    logic sp1_tx;
    logic sp1_rx;
  } dic_evt_t;

  typedef struct packed {
    logic [6:0]               s1, s2, s3, stbl;
    logic [DIC_NSRC-1:0]      mask, latched;
    logic                     nest, recon, powerup_context_reset_bit;
    logic [2:0]               edge_mode;
    logic                     genable, block, rst_req, ovf;
    logic [3:0]               active, req_lvl, depth;
    logic [11:0][3:0]         stk;
    logic [3:0]               pf_dir, pf_val;
    logic                     flag_out, req;
    logic [15:0]              vector;
    logic                     ph_act, ph_wr;
    logic [7:0]               ph_addr;
    logic [31:0]              rdata;
  } dic_state_t;

  localparam dic_state_t DIC_ST_RST = '{default: '0, s1: DIC_PIN_RST, s2: DIC_PIN_RST,
    s3: DIC_PIN_RST, stbl: DIC_PIN_RST, mask: DIC_MASK_RST, genable: 1'b1,
    rst_req: 1'b1, active: DIC_L_NONE, req_lvl: DIC_L_RESET, pf_dir: DIC_PFD_RST};
endpackage : dic_pkg

// ==== design/dic_top.sv ====
// prioritising interrupt controller with ahb-lite register slave
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dic_top (
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire dic_pkg::dic_pins_t pins_in,
  input  wire dic_pkg::dic_evt_t evt_in,
  input  wire logic              powerup_in,
  input  wire logic              int_ack_in,
  input  wire logic              int_return_in,
  output logic                   int_req_out,
  output logic      [15:0]       int_vector_out,
  output logic      [3:0]        pf_out_out,
  output logic      [3:0]        pf_oe_out,
  output logic                   flag_out_out,
  output logic                   flag_out_oe_out
);
  dic_pkg::dic_state_t st;
  dic_pkg::dic_state_t nx;
  logic [6:0]                  stbl_n;
  logic [6:0]                  fall;
  logic [dic_pkg::DIC_NSRC-1:0] eset, lvl, pend, cand, allow, force_set, clr;
  logic                        take, wr, found, acked;
  logic [3:0]                  sel;
  logic [31:0]                 rd;

  always_comb begin
    nx = st;
    // three-stage pin synchroniser; a change counts once stages two and three agree
    nx.s1 = pins_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    stbl_n = (st.s2 & st.s3) | (st.stbl & (st.s2 ^ st.s3));
    nx.stbl = stbl_n;
    fall = st.stbl & ~stbl_n;

    // ahb-lite: one address phase, zero-wait data phase
    take = hsel_in && htrans_in[1] && hready_in;
    wr = st.ph_act && st.ph_wr;
    nx.ph_act = take;
    nx.ph_wr = hwrite_in;
    nx.ph_addr = haddr_in[7:0];

    // edge requests; internal events arrive as one-cycle pulses
    eset = '0;
    eset[dic_pkg::DIC_L_PWD] = evt_in.pwd;
    eset[dic_pkg::DIC_L_SEL_A] = st.edge_mode[0] && fall[dic_pkg::DIC_P_SEL_A];
    eset[dic_pkg::DIC_L_SP0_TX] = evt_in.sp0_tx;
    eset[dic_pkg::DIC_L_SP0_RX] = evt_in.sp0_rx;
    eset[dic_pkg::DIC_L_EDGE] = fall[dic_pkg::DIC_P_EDGE];
    eset[dic_pkg::DIC_L_DMA] = evt_in.dma;
    eset[dic_pkg::DIC_L_TIMER] = evt_in.timer;
    // reconfigured port one lines replace its serial events
    eset[dic_pkg::DIC_L_SP1_TX] = st.recon ? (st.edge_mode[2] && fall[dic_pkg::DIC_P_FS_TX])
                                           : evt_in.sp1_tx;
    eset[dic_pkg::DIC_L_SP1_RX] = st.recon ? (st.edge_mode[1] && fall[dic_pkg::DIC_P_FS_RX])
                                           : evt_in.sp1_rx;

    // level requests are pending only while the pin is low
    lvl = '0;
    lvl[dic_pkg::DIC_L_SEL_A] = !st.edge_mode[0] && !st.stbl[dic_pkg::DIC_P_SEL_A];
    lvl[dic_pkg::DIC_L_LVL_B] = !st.stbl[dic_pkg::DIC_P_LVL_B];
    lvl[dic_pkg::DIC_L_LVL_A] = !st.stbl[dic_pkg::DIC_P_LVL_A];
    lvl[dic_pkg::DIC_L_SP1_TX] = st.recon && !st.edge_mode[2] && !st.stbl[dic_pkg::DIC_P_FS_TX];
    lvl[dic_pkg::DIC_L_SP1_RX] = st.recon && !st.edge_mode[1] && !st.stbl[dic_pkg::DIC_P_FS_RX];

    // force/clear register: write-only, also the software interrupt path
    force_set = '0;
    clr = '0;
    if (wr && st.ph_addr == dic_pkg::DIC_OFF_FC) begin
      force_set = hwdata_in[dic_pkg::DIC_NSRC-1:0];
      clr = hwdata_in[dic_pkg::DIC_FC_CLR_LSB +: dic_pkg::DIC_NSRC];
    end

    // selection; only the power-down bit ignores the mask
    pend = st.latched | lvl;
    cand = pend & (st.mask | 11'h001);
    for (int i = 0; i < dic_pkg::DIC_NSRC; i++) begin
      allow[i] = (st.active == dic_pkg::DIC_L_NONE) || (st.nest && (i < int'(st.active)));
    end
    cand = cand & allow;
    if (!st.genable || st.block) begin
      cand = '0;
    end
    found = 1'b0;
    sel = 4'h0;
    for (int i = dic_pkg::DIC_NSRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        found = 1'b1;
        sel = 4'(i);
      end
    end

    // acknowledge, entry push and return pop
    acked = int_ack_in && st.req;
    if (acked) begin
      if (st.req_lvl == dic_pkg::DIC_L_RESET) begin
        nx.rst_req = 1'b0;
        nx.active = dic_pkg::DIC_L_NONE;
        nx.depth = 4'h0;
      end else begin
        if (st.depth < dic_pkg::DIC_STK_DEPTH) begin
          nx.stk[st.depth] = st.active;
          nx.depth = st.depth + 4'h1;
        end else begin
          nx.ovf = 1'b1; // interrupted level is not pushed and is lost, so software must see it
        end
        nx.active = st.req_lvl;
        clr[st.req_lvl] = 1'b1;
      end
    end else if (int_return_in && st.depth != 4'h0) begin
      nx.active = st.stk[st.depth - 4'h1];
      nx.depth = st.depth - 4'h1;
    end
    // set wins over clear for every latched request
    nx.latched = (st.latched & ~clr) | eset | force_set;

    // power-up with context reset restarts at the reset vector
    if (powerup_in && st.powerup_context_reset_bit) begin
      nx.rst_req = 1'b1;
    end

    // registered request; reset outranks everything, even global off
    nx.block = 1'b0;
    if (nx.rst_req) begin
      nx.req = 1'b1;
      nx.req_lvl = dic_pkg::DIC_L_RESET;
      nx.vector = dic_pkg::DIC_VEC_RESET;
    end else begin
      nx.req = found && !acked;
      nx.req_lvl = sel;
      nx.vector = dic_pkg::DIC_VEC_TABLE[sel];
    end

    // register writes in the data phase
    if (wr) begin
      unique case (st.ph_addr)
        dic_pkg::DIC_OFF_MASK: begin
          nx.mask = hwdata_in[dic_pkg::DIC_NSRC-1:0];
          nx.block = 1'b1;
        end
        dic_pkg::DIC_OFF_CTRL: begin
          nx.nest = hwdata_in[dic_pkg::DIC_CTRL_NEST];
          nx.edge_mode = hwdata_in[dic_pkg::DIC_CTRL_EDGE_C:dic_pkg::DIC_CTRL_EDGE_A];
          nx.recon = hwdata_in[dic_pkg::DIC_CTRL_RECON];
          nx.powerup_context_reset_bit = hwdata_in[dic_pkg::DIC_CTRL_POWERUP_CONTEXT_RESET_BIT];
        end
        dic_pkg::DIC_OFF_GLOBAL: begin
          // on and off written together leave the state unchanged
          if (hwdata_in[dic_pkg::DIC_GL_ON] && !hwdata_in[dic_pkg::DIC_GL_OFF]) begin
            nx.genable = 1'b1;
          end else if (hwdata_in[dic_pkg::DIC_GL_OFF] && !hwdata_in[dic_pkg::DIC_GL_ON]) begin
            nx.genable = 1'b0;
          end
        end
        dic_pkg::DIC_OFF_STATUS: begin
          nx.ovf = st.ovf && !hwdata_in[dic_pkg::DIC_ST_OVF];
        end
        dic_pkg::DIC_OFF_FLAG: begin
          nx.pf_dir = hwdata_in[3:0];
          nx.pf_val = hwdata_in[dic_pkg::DIC_FL_VAL_LSB +: 4];
          nx.flag_out = hwdata_in[dic_pkg::DIC_FL_FLAG_OUT];
        end
        default: begin
        end
      endcase
    end

    // read data captured at the address phase; unmapped offsets read zero
    rd = '0;
    unique case (haddr_in[7:0])
      dic_pkg::DIC_OFF_MASK: rd[dic_pkg::DIC_NSRC-1:0] = st.mask;
      dic_pkg::DIC_OFF_CTRL: rd[5:0] = {st.powerup_context_reset_bit, st.recon, st.edge_mode, st.nest};
      dic_pkg::DIC_OFF_GLOBAL: rd[dic_pkg::DIC_GL_ON] = st.genable;
      dic_pkg::DIC_OFF_STATUS: begin
        rd[dic_pkg::DIC_NSRC-1:0] = pend;
        rd[dic_pkg::DIC_ST_DEPTH_LSB +: 4] = st.depth;
        rd[dic_pkg::DIC_ST_ACTIVE_LSB +: 4] = st.active;
        rd[dic_pkg::DIC_ST_OVF] = st.ovf;
      end
      dic_pkg::DIC_OFF_FLAG: begin
        rd[3:0] = st.pf_dir;
        rd[dic_pkg::DIC_FL_VAL_LSB +: 4] = st.pf_val;
        rd[dic_pkg::DIC_FL_FLAG_OUT] = st.flag_out;
        rd[dic_pkg::DIC_FL_PIN_LSB +: 4] = st.stbl[3:0];
        rd[dic_pkg::DIC_FL_FLAG_IN] = st.stbl[dic_pkg::DIC_P_DR];
      end
      default: rd = '0;
    endcase
    nx.rdata = (take && !hwrite_in) ? rd : '0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      st <= dic_pkg::DIC_ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign hrdata_out      = st.rdata;
  assign hreadyout_out   = 1'b1;
  assign hresp_out       = 1'b0;
  assign int_req_out     = st.req;
  assign int_vector_out  = st.vector;
  assign pf_out_out      = st.pf_val;
  assign pf_oe_out       = st.pf_dir;
  assign flag_out_out    = st.flag_out;
  assign flag_out_oe_out = st.recon;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence mask_write_s;
    wr && st.ph_addr == dic_pkg::DIC_OFF_MASK;
  endsequence
  sequence quiet_s;
    !st.rst_req && !powerup_in;
  endsequence

  reset_vector_a: assert property (st.rst_req && $past(resetn_in) |-> int_req_out
    && int_vector_out == dic_pkg::DIC_VEC_RESET) else $error("reset vector not shown");
  mask_block_a: assert property (mask_write_s ##0 quiet_s ##1 quiet_s |=> !int_req_out)
    else $error("request during mask write shadow");
  global_off_a: assert property (!st.genable ##0 quiet_s |=> !int_req_out)
    else $error("request while globally disabled");
  seq_mode_a: assert property (!st.nest && st.active != dic_pkg::DIC_L_NONE ##0 quiet_s
    |=> !int_req_out) else $error("preemption in sequential mode");
  nest_prio_a: assert property (int_req_out && st.req_lvl != dic_pkg::DIC_L_RESET
    && st.active != dic_pkg::DIC_L_NONE |-> st.req_lvl < $past(st.active))
    else $error("nested request not higher priority");
  mask_gate_a: assert property (int_req_out && st.req_lvl != dic_pkg::DIC_L_RESET
    && st.req_lvl != 4'h0 |-> (($past(st.mask) >> st.req_lvl) & 11'h001) != 11'h000)
    else $error("masked level requested");
  pwd_unmasked_a: assert property (st.latched[0] && st.genable && !st.block
    && st.active == dic_pkg::DIC_L_NONE && !int_ack_in ##0 quiet_s
    |=> int_req_out && int_vector_out == 16'h002C) else $error("power-down not served");
  stack_push_a: assert property (int_ack_in && int_req_out && st.req_lvl != dic_pkg::DIC_L_RESET
    && st.depth < dic_pkg::DIC_STK_DEPTH |=> st.depth == $past(st.depth) + 4'h1
    && st.active == $past(st.req_lvl)) else $error("entry did not push");
  edge_latch_a: assert property (fall[dic_pkg::DIC_P_EDGE] |=> st.latched[dic_pkg::DIC_L_EDGE])
    else $error("edge request not latched");
  reg_rdata_a: assert property (take && !hwrite_in && haddr_in[7:0] == dic_pkg::DIC_OFF_FC
    |=> hrdata_out == 32'h0000_0000) else $error("force-clear readable");
endmodule : dic_top
`default_nettype wire

// ==== testbench/dic_seq_model.sv ====
// sequencer model: takes shown vectors and returns from service
`timescale 1ns/1ps
`default_nettype none
module dic_seq_model #(
  parameter int HOLD = 3
) (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        int_req_in,
  input  wire logic [15:0] int_vector_in,
  input  wire logic        ack_en_in,
  input  wire logic        ret_en_in,
  output logic             int_ack_out,
  output logic             int_return_out,
  output logic      [15:0] last_vec_out,
  output var int           taken_out
);
  int owed;
  int wait_cnt;
  // ack only while a request is shown, one cycle, so it is never counted twice
  always @(posedge clk_sys_in) begin
    int_return_out <= 1'b0;
    if (!resetn_in) begin
      int_ack_out <= 1'b0;
      owed <= 0;
      wait_cnt <= 0;
      taken_out <= 0;
    end else begin
      int_ack_out <= ack_en_in & int_req_in & !int_ack_out;
      if (int_ack_out && int_req_in) begin
        taken_out <= taken_out + 1;
        last_vec_out <= int_vector_in;
        owed <= owed + 1;
        wait_cnt <= HOLD;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else if (owed > 0 && ret_en_in && !int_return_out && !int_ack_out) begin
        int_return_out <= 1'b1;
        owed <= owed - 1;
      end
    end
  end
endmodule : dic_seq_model
`default_nettype wire

// ==== testbench/test_dic_top.sv ====
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_dic_top;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, powerup = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hready, hresp, req, ack, ret, foe, fout, ack_en = 1'b1, ret_en = 1'b1;
  logic [15:0] vec, last;
  logic [3:0] pfo, pfoe;
  dic_pkg::dic_pins_t pins = 7'h7F;
  dic_pkg::dic_evt_t evt = '0;
  int taken, bad_count = 0, n_checks = 0, cyc = 0;
  logic [15:0] vt [11] = '{16'h002C, 16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014,
    16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028};
  always #50 clk = ~clk;
  dic_top dut (.clk_sys_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .pins_in(pins), .evt_in(evt), .powerup_in(powerup), .int_ack_in(ack),
    .int_return_in(ret), .int_req_out(req), .int_vector_out(vec), .pf_out_out(pfo),
    .pf_oe_out(pfoe), .flag_out_out(fout), .flag_out_oe_out(foe));
  dic_seq_model #(.HOLD(3)) seq (.clk_sys_in(clk), .resetn_in(rstn), .int_req_in(req),
    .int_vector_in(vec), .ack_en_in(ack_en), .ret_en_in(ret_en), .int_ack_out(ack),
    .int_return_out(ret), .last_vec_out(last), .taken_out(taken));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic wait_vec(input logic [15:0] v);
    int t0;
    t0 = taken;
    for (int i = 0; i < 80 && taken == t0; i++) @(posedge clk);
    check({16'h0, last}, {16'h0, v});
  endtask : wait_vec
  task automatic quiet;
    int t0;
    t0 = taken;
    repeat (20) @(posedge clk);
    check(taken, t0);
  endtask : quiet
  task automatic pulse_pin(input int p, input logic hit, input logic [15:0] v);
    @(posedge clk);
    ack_en <= 1'b0;
    pins[p] <= 1'b0;
    repeat (8) @(posedge clk);
    pins[p] <= 1'b1;
    repeat (10) @(posedge clk);
    ack_en <= 1'b1;
    if (hit) wait_vec(v);
    else quiet();
  endtask : pulse_pin
  task automatic t_reset;
    logic [31:0] r;
    wait_vec(16'h0000);
    bus(1'b0, 8'h0C, 0, r);
    check(r[0], 1);
    check(pfoe, 0);
    check(foe, 0);
    bus(1'b0, 8'h08, 0, r);
    check(r, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_vectors;
    wr(8'h00, 32'h7FF);
    for (int i = 0; i < 11; i++) begin
      wr(8'h08, 32'h1 << i);
      wait_vec(vt[i]);
    end
    wr(8'h08, 32'h402);
    wait_vec(16'h0004);
    wait_vec(16'h0028);
    $display("vector test done");
  endtask : t_vectors
  task automatic t_mask;
    logic [31:0] r;
    logic low;
    wr(8'h00, 32'h000);
    @(posedge clk);
    evt.timer <= 1'b1;
    @(posedge clk);
    evt.timer <= 1'b0;
    quiet();
    evt.pwd <= 1'b1;
    @(posedge clk);
    evt.pwd <= 1'b0;
    wait_vec(16'h002C);
    ack_en <= 1'b0;
    wr(8'h00, 32'h7FF);
    repeat (10) @(posedge clk);
    check(req, 1);
    for (int i = 0; i < 6 && req !== 1'b1; i++) @(posedge clk);
    wr(8'h00, 32'h7FF);
    low = 1'b0;
    repeat (3) @(posedge clk) low = low | (req === 1'b0);
    check(low, 1);
    ack_en <= 1'b1;
    wait_vec(16'h0028);
    wr(8'h0C, 32'h2);
    wr(8'h08, 32'h401);
    quiet();
    bus(1'b0, 8'h0C, 0, r);
    check(r[0], 0);
    wr(8'h08, 32'h0400_0000);
    wr(8'h0C, 32'h1);
    wait_vec(16'h002C);
    quiet();
    $display("mask test done");
  endtask : t_mask
  task automatic t_pins;
    logic [31:0] r;
    ret_en <= 1'b0;
    pins.ext_int_level_a_n <= 1'b0;
    wait_vec(16'h000C);
    pins.ext_int_level_a_n <= 1'b1;
    repeat (10) @(posedge clk);
    ret_en <= 1'b1;
    pulse_pin(dic_pkg::DIC_P_LVL_B, 1'b0, 0);
    pulse_pin(dic_pkg::DIC_P_SEL_A, 1'b0, 0);
    pulse_pin(dic_pkg::DIC_P_EDGE, 1'b1, 16'h0018);
    wr(8'h04, 32'h02);
    pulse_pin(dic_pkg::DIC_P_SEL_A, 1'b1, 16'h0004);
    wr(8'h04, 32'h1C);
    pulse_pin(dic_pkg::DIC_P_FS_TX, 1'b1, 16'h0020);
    pulse_pin(dic_pkg::DIC_P_FS_RX, 1'b1, 16'h0024);
    check(foe, 1);
    pins.sp1_dr <= 1'b0;
    repeat (6) @(posedge clk);
    bus(1'b0, 8'h14, 0, r);
    check(r[20], 0);
    wr(8'h14, 32'h15F);
    @(posedge clk);
    check({fout, pfoe, pfo}, 9'h1F5);
    $display("pin test done");
  endtask : t_pins
  task automatic t_nest;
    logic [31:0] r;
    wr(8'h04, 32'h01);
    ret_en <= 1'b0;
    wr(8'h08, 32'h400);
    wait_vec(16'h0028);
    wr(8'h08, 32'h002);
    wait_vec(16'h0004);
    bus(1'b0, 8'h10, 0, r);
    check(r[19:16], 2);
    wr(8'h08, 32'h400);
    quiet();
    ret_en <= 1'b1;
    wait_vec(16'h0028);
    repeat (10) @(posedge clk);
    wr(8'h04, 32'h00);
    ret_en <= 1'b0;
    wr(8'h08, 32'h080);
    wait_vec(16'h001C);
    wr(8'h08, 32'h002);
    quiet();
    ret_en <= 1'b1;
    wait_vec(16'h0004);
    repeat (10) @(posedge clk);
    wr(8'h04, 32'h20);
    @(posedge clk);
    powerup <= 1'b1;
    @(posedge clk);
    powerup <= 1'b0;
    wait_vec(16'h0000);
    $display("nesting test done");
  endtask : t_nest
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_vectors();
    t_mask();
    t_pins();
    t_nest();
    complete_run();
  end
endmodule : test_dic_top
`default_nettype wire
